// ### include/addr_decode_pkg.sv
// Package holding the address map constants and carrier types for the decoder
//
// Functional notes
// - Data addresses 0xC000-0xFFFF go to one of 64 16k flash pages chosen by the upper page select, default page 0x04000-0x07FFF.
// - Data addresses 0x8000-0xBFFF go to a 16k flash page chosen by the mid page select, default starting at 0x04000.
// - Inside 0x7000-0x7FFF the serial engine, ISA, buffer manager, power, configuration and runtime register groups are decoded.
// - A data access at exactly 0x6000 goes to the internal packet buffer manager data register.
// - Data addresses 0x5000-0x5FFF are forwarded to the ISA bus as memory cycles.
// - Data addresses 0x4000-0x40FF are forwarded to the ISA bus as I/O cycles.
// - Data addresses 0x0000-0x00FF are core registers and never reach an external bus.
// - Internal block register accesses still put the address on the flash bus but keep both flash strobes inactive.
// - The packet buffer is seen by the ISA DMA controller as 32 independent 1k blocks in its 64K map.
// - An allocated packet appears to the ISA DMA controller as one contiguous block over its scattered pages.
// - ISA DMA controller addresses 0x8000-0xFFFF select one 1K packet window per block.
// - ISA DMA controller addresses 0x0000-0x7FFF pass to external ISA RAM as a 32K window.
package addr_decode_pkg;

	localparam logic [15:0] FLASH_UPPER_SEL_ADDR = 16'h7f29;
	localparam logic [15:0] FLASH_MID_SEL_ADDR   = 16'h7f28;
	localparam logic [15:0] ISA_IO_BASE_ADDR     = 16'h7f71;
	localparam logic [15:0] ISA_MEM_BASE_ADDR    = 16'h7f72;
	localparam logic [15:0] PBUF_DATA_ADDR       = 16'h6000;

	localparam logic [5:0]  FLASH_UPPER_RESET    = 6'h01;
	localparam logic [5:0]  FLASH_MID_RESET      = 6'h01;
	localparam logic [7:0]  ISA_IO_BASE_RESET    = 8'h00;
	localparam logic [7:0]  ISA_MEM_BASE_RESET   = 8'h00;

	localparam logic [1:0]  QTR_UPPER            = 2'h3;
	localparam logic [1:0]  QTR_MID              = 2'h2;
	localparam logic [3:0]  NIB_INTERNAL         = 4'h7;
	localparam logic [3:0]  NIB_PBUF             = 4'h6;
	localparam logic [3:0]  NIB_ISA_MEM          = 4'h5;
	localparam logic [3:0]  NIB_ISA_IO           = 4'h4;
	localparam logic [3:0]  NIB_CORE             = 4'h0;
	localparam logic [3:0]  PAGE_ZERO_NIB        = 4'h0;

	localparam int          BLK_COUNT            = 6;
	localparam logic [7:0]  BLK_LO [BLK_COUNT]   = '{8'h80, 8'h70, 8'h50, 8'h20, 8'h10, 8'h00};
	localparam logic [7:0]  BLK_HI [BLK_COUNT]   = '{8'h9f, 8'h7f, 8'h6f, 8'h2f, 8'h1f, 8'h0f};
	localparam logic [7:0]  BLK_PAGE             = 8'h7f;
	localparam logic [3:0]  INT_PAD              = 4'h0;
	localparam logic [7:0]  RDATA_IDLE           = 8'h00;

	typedef struct packed {
		logic [19:0]          flash_addr;
		logic                 flash_rd_n;
		logic                 flash_wr_n;
		logic [19:0]          isa_addr;
		logic                 isa_mem_rd;
		logic                 isa_mem_wr;
		logic                 isa_io_rd;
		logic                 isa_io_wr;
		logic                 pbuf_rd;
		logic                 pbuf_wr;
		logic [BLK_COUNT-1:0] blk_sel;
		logic                 blk_rd;
		logic                 blk_wr;
		logic [7:0]           wdata;
	} mcu_out_type;

	typedef struct packed {
		logic                 pbuf_sel;
		logic [4:0]           packet_number;
		logic [2:0]           page_index;
		logic [6:0]           page_offset;
		logic                 ram_sel;
		logic [14:0]          ram_addr;
	} dma_out_type;

endpackage

// ### rtl/mcu_and_dma_address_decoder.sv
// Data space and DMA address decoder with flash page and ISA window registers
`timescale 1ns/1ps
`default_nettype none

module mcu_and_dma_address_decoder (
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_nrst,
	input  wire logic [15:0]                  i_mcu_addr,
	input  wire logic                         i_mcu_rd,
	input  wire logic                         i_mcu_wr,
	input  wire logic [7:0]                   i_mcu_wdata,
	input  wire logic [7:0]                   i_flash_rdata,
	input  wire logic [7:0]                   i_isa_rdata,
	input  wire logic [7:0]                   i_blk_rdata,
	input  wire logic [15:0]                  i_dma_addr,
	input  wire logic                         i_dma_valid,
	output var  addr_decode_pkg::mcu_out_type o_mcu_out,
	output logic [7:0]                        o_mcu_rdata,
	output var  addr_decode_pkg::dma_out_type o_dma_out,
	output logic                              o_dma_valid
);

	// ************************************************************
	// Page and window registers
	// ************************************************************
	logic [5:0] flash_upper_page_select_r, flash_upper_page_select_nxt;
	logic [5:0] flash_mid_page_select_r,   flash_mid_page_select_nxt;
	logic [7:0] isa_io_window_base_r,      isa_io_window_base_nxt;
	logic [7:0] isa_memory_window_base_r,  isa_memory_window_base_nxt;

	always_comb begin
		flash_upper_page_select_nxt = flash_upper_page_select_r;
		flash_mid_page_select_nxt   = flash_mid_page_select_r;
		isa_io_window_base_nxt      = isa_io_window_base_r;
		isa_memory_window_base_nxt  = isa_memory_window_base_r;
		if (i_mcu_wr) begin
			unique case (i_mcu_addr)
				addr_decode_pkg::FLASH_UPPER_SEL_ADDR: flash_upper_page_select_nxt = i_mcu_wdata[5:0];
				addr_decode_pkg::FLASH_MID_SEL_ADDR:   flash_mid_page_select_nxt   = i_mcu_wdata[5:0];
				addr_decode_pkg::ISA_IO_BASE_ADDR:     isa_io_window_base_nxt      = i_mcu_wdata;
				addr_decode_pkg::ISA_MEM_BASE_ADDR:    isa_memory_window_base_nxt  = i_mcu_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			flash_upper_page_select_r <= addr_decode_pkg::FLASH_UPPER_RESET;
			flash_mid_page_select_r   <= addr_decode_pkg::FLASH_MID_RESET;
			isa_io_window_base_r      <= addr_decode_pkg::ISA_IO_BASE_RESET;
			isa_memory_window_base_r  <= addr_decode_pkg::ISA_MEM_BASE_RESET;
		end else begin
			flash_upper_page_select_r <= flash_upper_page_select_nxt;
			flash_mid_page_select_r   <= flash_mid_page_select_nxt;
			isa_io_window_base_r      <= isa_io_window_base_nxt;
			isa_memory_window_base_r  <= isa_memory_window_base_nxt;
		end
	end

	// ************************************************************
	// Microcontroller data space decode
	// ************************************************************
	localparam int                BLK_SEL_W = addr_decode_pkg::BLK_COUNT;
	addr_decode_pkg::mcu_out_type mcu_out_r, mcu_out_nxt;
	logic [7:0]                   rdata_r, rdata_nxt;
	logic [BLK_SEL_W-1:0]         blk_hit;
	logic                         ext_flash;
	logic                         internal;

	generate
		for (genvar g = 0; g < BLK_SEL_W; g++) begin : g_blk
			assign blk_hit[g] = (i_mcu_addr[15:8] == addr_decode_pkg::BLK_PAGE)
				&& (i_mcu_addr[7:0] >= addr_decode_pkg::BLK_LO[g])
				&& (i_mcu_addr[7:0] <= addr_decode_pkg::BLK_HI[g]);
		end
	endgenerate

	always_comb begin
		mcu_out_nxt            = '0;
		mcu_out_nxt.flash_rd_n = 1'b1;
		mcu_out_nxt.flash_wr_n = 1'b1;
		mcu_out_nxt.wdata      = i_mcu_wdata;
		mcu_out_nxt.flash_addr = mcu_out_r.flash_addr;
		ext_flash              = 1'b0;
		internal               = 1'b0;
		rdata_nxt              = addr_decode_pkg::RDATA_IDLE;
		if (i_mcu_addr[15:14] == addr_decode_pkg::QTR_UPPER) begin
			mcu_out_nxt.flash_addr = {flash_upper_page_select_r, i_mcu_addr[13:0]};
			ext_flash              = 1'b1;
		end else if (i_mcu_addr[15:14] == addr_decode_pkg::QTR_MID) begin
			mcu_out_nxt.flash_addr = {flash_mid_page_select_r, i_mcu_addr[13:0]};
			ext_flash              = 1'b1;
		end else if (i_mcu_addr[15:12] == addr_decode_pkg::NIB_INTERNAL) begin
			internal            = 1'b1;
			mcu_out_nxt.blk_sel = blk_hit;
		end else if (i_mcu_addr == addr_decode_pkg::PBUF_DATA_ADDR) begin
			internal            = 1'b1;
			mcu_out_nxt.pbuf_rd = i_mcu_rd;
			mcu_out_nxt.pbuf_wr = i_mcu_wr;
		end else if (i_mcu_addr[15:12] == addr_decode_pkg::NIB_ISA_MEM) begin
			mcu_out_nxt.isa_addr   = {isa_memory_window_base_r, i_mcu_addr[11:0]};
			mcu_out_nxt.isa_mem_rd = i_mcu_rd;
			mcu_out_nxt.isa_mem_wr = i_mcu_wr;
			rdata_nxt              = i_isa_rdata;
		end else if (i_mcu_addr[15:12] == addr_decode_pkg::NIB_ISA_IO
			&& i_mcu_addr[11:8] == addr_decode_pkg::PAGE_ZERO_NIB) begin
			mcu_out_nxt.isa_addr  = {addr_decode_pkg::INT_PAD, isa_io_window_base_r, i_mcu_addr[7:0]};
			mcu_out_nxt.isa_io_rd = i_mcu_rd;
			mcu_out_nxt.isa_io_wr = i_mcu_wr;
			rdata_nxt             = i_isa_rdata;
		end
		// Core range and unused ranges fall through with every strobe idle
		if (ext_flash) begin
			mcu_out_nxt.flash_rd_n = ~i_mcu_rd;
			mcu_out_nxt.flash_wr_n = ~i_mcu_wr;
			rdata_nxt              = i_flash_rdata;
		end
		if (internal) begin
			mcu_out_nxt.flash_addr = {addr_decode_pkg::INT_PAD, i_mcu_addr};
			mcu_out_nxt.blk_rd     = i_mcu_rd;
			mcu_out_nxt.blk_wr     = i_mcu_wr;
			rdata_nxt              = i_blk_rdata;
			unique case (i_mcu_addr)
				addr_decode_pkg::FLASH_UPPER_SEL_ADDR: rdata_nxt = {2'b00, flash_upper_page_select_r};
				addr_decode_pkg::FLASH_MID_SEL_ADDR:   rdata_nxt = {2'b00, flash_mid_page_select_r};
				addr_decode_pkg::ISA_IO_BASE_ADDR:     rdata_nxt = isa_io_window_base_r;
				addr_decode_pkg::ISA_MEM_BASE_ADDR:    rdata_nxt = isa_memory_window_base_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			mcu_out_r            <= '0;
			mcu_out_r.flash_rd_n <= 1'b1;
			mcu_out_r.flash_wr_n <= 1'b1;
			rdata_r              <= addr_decode_pkg::RDATA_IDLE;
		end else begin
			mcu_out_r <= mcu_out_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign o_mcu_out   = mcu_out_r;
	assign o_mcu_rdata = rdata_r;

	// ************************************************************
	// ISA DMA controller address split
	// ************************************************************
	addr_decode_pkg::dma_out_type dma_out_r, dma_out_nxt;
	logic                         dma_valid_r, dma_valid_nxt;

	always_comb begin
		dma_out_nxt               = '0;
		dma_valid_nxt             = i_dma_valid;
		dma_out_nxt.pbuf_sel      = i_dma_addr[15];
		dma_out_nxt.ram_sel       = ~i_dma_addr[15];
		if (i_dma_addr[15]) begin
			dma_out_nxt.packet_number = i_dma_addr[14:10];
			dma_out_nxt.page_index    = i_dma_addr[9:7];
			dma_out_nxt.page_offset   = i_dma_addr[6:0];
		end else begin
			dma_out_nxt.ram_addr      = i_dma_addr[14:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			dma_out_r   <= '0;
			dma_valid_r <= 1'b0;
		end else begin
			dma_out_r   <= dma_out_nxt;
			dma_valid_r <= dma_valid_nxt;
		end
	end

	assign o_dma_out   = dma_out_r;
	assign o_dma_valid = dma_valid_r;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_upper_rd;
		i_mcu_rd && i_mcu_addr[15:14] == addr_decode_pkg::QTR_UPPER;
	endsequence

	property p_upper_page;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_upper_rd |=> !o_mcu_out.flash_rd_n
			&& o_mcu_out.flash_addr == {$past(flash_upper_page_select_r), $past(i_mcu_addr[13:0])};
	endproperty
	a_upper_page: assert property (p_upper_page) else $error("upper flash page address wrong");

	property p_mid_page;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_wr && i_mcu_addr[15:14] == addr_decode_pkg::QTR_MID)
			|=> !o_mcu_out.flash_wr_n && o_mcu_out.flash_addr[19:14] == $past(flash_mid_page_select_r);
	endproperty
	a_mid_page: assert property (p_mid_page) else $error("mid flash page address wrong");

	property p_page_write;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_wr && i_mcu_addr == addr_decode_pkg::FLASH_UPPER_SEL_ADDR) ##1 s_upper_rd
			|=> o_mcu_out.flash_addr[19:14] == $past(i_mcu_wdata[5:0], 2);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page select write not used");

	property p_blk_sel;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_addr == 16'h7f75) |=> o_mcu_out.blk_sel == 6'b00_0010;
	endproperty
	a_blk_sel: assert property (p_blk_sel) else $error("ISA register group not selected");

	property p_internal_quiet;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		((i_mcu_rd || i_mcu_wr) && i_mcu_addr[15:12] == addr_decode_pkg::NIB_INTERNAL)
			|=> o_mcu_out.flash_rd_n && o_mcu_out.flash_wr_n && o_mcu_out.flash_addr[15:0] == $past(i_mcu_addr);
	endproperty
	a_internal_quiet: assert property (p_internal_quiet) else $error("flash strobe on internal access");

	property p_pbuf;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_rd && i_mcu_addr == addr_decode_pkg::PBUF_DATA_ADDR) |=> o_mcu_out.pbuf_rd && o_mcu_out.flash_rd_n;
	endproperty
	a_pbuf: assert property (p_pbuf) else $error("packet buffer data read not routed");

	property p_isa_mem;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_wr && i_mcu_addr[15:12] == addr_decode_pkg::NIB_ISA_MEM)
			|=> o_mcu_out.isa_mem_wr && o_mcu_out.isa_addr[11:0] == $past(i_mcu_addr[11:0]);
	endproperty
	a_isa_mem: assert property (p_isa_mem) else $error("ISA memory window not forwarded");

	property p_isa_io;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_rd && i_mcu_addr[15:8] == 8'h40) |=> o_mcu_out.isa_io_rd && !o_mcu_out.isa_mem_rd;
	endproperty
	a_isa_io: assert property (p_isa_io) else $error("ISA I/O window not forwarded");

	property p_no_strobe;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_mcu_addr[15:12] == addr_decode_pkg::NIB_CORE || (i_mcu_addr[15:14] == 2'b00 && i_mcu_addr[13:12] != 2'b00))
			|=> o_mcu_out.flash_rd_n && o_mcu_out.flash_wr_n && !o_mcu_out.isa_mem_rd
			&& !o_mcu_out.isa_mem_wr && !o_mcu_out.isa_io_rd && !o_mcu_out.isa_io_wr;
	endproperty
	a_no_strobe: assert property (p_no_strobe) else $error("external strobe on core or unused range");

	property p_dma_split;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		i_dma_valid |=> o_dma_valid && (o_dma_out.pbuf_sel != o_dma_out.ram_sel)
			&& (o_dma_out.pbuf_sel ? {o_dma_out.packet_number, o_dma_out.page_index, o_dma_out.page_offset}
				== $past(i_dma_addr[14:0]) : o_dma_out.ram_addr == $past(i_dma_addr[14:0]));
	endproperty
	a_dma_split: assert property (p_dma_split) else $error("DMA address split wrong");

endmodule // mcu_and_dma_address_decoder

`default_nettype wire

// ### tb/far_side_model.sv
// Far side model giving flash, ISA and block register read data
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
	input  wire logic [15:0] i_addr,
	output logic      [7:0]  o_flash_rdata,
	output logic      [7:0]  o_isa_rdata,
	output logic      [7:0]  o_blk_rdata
);
	// Distinct pattern per source so a wrong read path shows
	assign o_flash_rdata = i_addr[7:0] ^ 8'h5a;
	assign o_isa_rdata   = i_addr[7:0] ^ 8'ha5;
	assign o_blk_rdata   = i_addr[15:8] ^ i_addr[7:0];
endmodule // far_side_model

`default_nettype wire

// ### tb/tb_mcu_and_dma_address_decoder.sv
// Self-checking bench for the data space and DMA address decoder
`timescale 1ns/1ps
`default_nettype none

module tb_mcu_and_dma_address_decoder;
	logic                         clk   = 1'h0;
	logic                         nrst  = 1'h0;
	logic [15:0]                  addr  = 16'h0;
	logic                         rd    = 1'h0;
	logic                         wr    = 1'h0;
	logic [7:0]                   wd    = 8'h0;
	logic [15:0]                  da    = 16'h0;
	logic                         dv    = 1'h0;
	logic [7:0]                   fr;
	logic [7:0]                   ir;
	logic [7:0]                   br;
	addr_decode_pkg::mcu_out_type mo;
	logic [7:0]                   rdat;
	addr_decode_pkg::dma_out_type dout;
	logic                         dval;
	logic [5:0]                   up;
	logic [5:0]                   mid;
	logic [7:0]                   iob;
	logic [7:0]                   memb;
	logic [19:0]                  last;
	int                           mismatches = 0;
	int                           n_tests    = 0;
	int                           cyc        = 0;
	logic [15:0]                  ca [19] = '{16'h7f29, 16'hc000, 16'h7f28, 16'hbfff, 16'h7f71, 16'h40ff,
		16'h4100, 16'h7f72, 16'h5fff, 16'h6000, 16'h6001, 16'h00ff, 16'h7f9f, 16'h7fa0, 16'h7f4f,
		16'h7f0f, 16'h1000, 16'h8c85, 16'h7f75};

	mcu_and_dma_address_decoder mcu_and_dma_address_decoder_i (.i_sys_clk(clk), .i_nrst(nrst),
		.i_mcu_addr(addr), .i_mcu_rd(rd), .i_mcu_wr(wr), .i_mcu_wdata(wd), .i_flash_rdata(fr),
		.i_isa_rdata(ir), .i_blk_rdata(br), .i_dma_addr(da), .i_dma_valid(dv), .o_mcu_out(mo),
		.o_mcu_rdata(rdat), .o_dma_out(dout), .o_dma_valid(dval));
	far_side_model far_side_model_i (.i_addr(addr), .o_flash_rdata(fr), .o_isa_rdata(ir), .o_blk_rdata(br));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	// ************************************************************
	// Checking and bus tasks
	// ************************************************************
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge clk);
		nrst = 1'h0;
		rd = 1'h0;
		wr = 1'h0;
		repeat (3) @(posedge clk);
		#1 chk("reset_out", mo, 64'h0000_0c00_0000_0000);
		@(negedge clk);
		nrst = 1'h1;
		up = 6'h01;
		mid = 6'h01;
		iob = 8'h00;
		memb = 8'h00;
		last = 20'h0;
		@(posedge clk);
	endtask

	// One request cycle; expectation built from the address map before the edge
	task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d, input logic [15:0] x,
		input logic v);
		addr_decode_pkg::mcu_out_type e;
		logic [7:0]                   er;
		@(negedge clk);
		addr = a;
		rd = !w;
		wr = w;
		wd = d;
		da = x;
		dv = v;
		e = '0;
		e.flash_rd_n = 1'h1;
		e.flash_wr_n = 1'h1;
		e.wdata = d;
		er = 8'h00;
		if (a[15]) begin
			last = {a[14] ? up : mid, a[13:0]};
			e.flash_rd_n = w;
			e.flash_wr_n = !w;
			er = a[7:0] ^ 8'h5a;
		end
		if (a[15:12] == 4'h7 || a == 16'h6000) begin
			last = {4'h0, a};
			e.blk_rd = !w;
			e.blk_wr = w;
			er = a[15:8] ^ a[7:0];
		end
		e.flash_addr = last;
		if (a[15:12] == 4'h5) begin
			e.isa_addr = {memb, a[11:0]};
			e.isa_mem_rd = !w;
			e.isa_mem_wr = w;
			er = a[7:0] ^ 8'ha5;
		end
		if (a[15:8] == 8'h40) begin
			e.isa_addr = {4'h0, iob, a[7:0]};
			e.isa_io_rd = !w;
			e.isa_io_wr = w;
			er = a[7:0] ^ 8'ha5;
		end
		e.pbuf_rd = (a == 16'h6000) && !w;
		e.pbuf_wr = (a == 16'h6000) && w;
		if (a[15:8] == 8'h7f) begin
			case (a[7:4])
				4'h0: e.blk_sel = 6'h20;
				4'h1: e.blk_sel = 6'h10;
				4'h2: e.blk_sel = 6'h08;
				4'h5, 4'h6: e.blk_sel = 6'h04;
				4'h7: e.blk_sel = 6'h02;
				4'h8, 4'h9: e.blk_sel = 6'h01;
				default: e.blk_sel = 6'h00;
			endcase
		end
		case (a)
			16'h7f28: er = {2'h0, mid};
			16'h7f29: er = {2'h0, up};
			16'h7f71: er = iob;
			16'h7f72: er = memb;
			default: ;
		endcase
		if (w) begin
			case (a)
				16'h7f28: mid = d[5:0];
				16'h7f29: up = d[5:0];
				16'h7f71: iob = d;
				16'h7f72: memb = d;
				default: ;
			endcase
		end
		@(posedge clk);
		#1 chk("mcu_out", mo, e);
		if (!w) chk("rdata", {56'h0, rdat}, {56'h0, er});
		chk("dma_valid", {63'h0, dval}, {63'h0, v});
		if (x[15]) chk("dma_pbuf", {dout.pbuf_sel, dout.packet_number, dout.page_index, dout.page_offset,
			dout.ram_sel}, {1'h1, x[14:0], 1'h0});
		else chk("dma_ram", {dout.pbuf_sel, dout.ram_sel, dout.ram_addr}, {2'h1, x[14:0]});
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		logic [31:0] r;
		logic [31:0] q;
		logic [15:0] a;
		void'($urandom(32'h1ed8));
		do_reset();
		access(16'hc000, 1'h0, 8'h00, 16'h8000, 1'h1);
		access(16'h8000, 1'h0, 8'h00, 16'h7fff, 1'h1);
		for (int k = 0; k < 19; k++) begin
			access(ca[k], 1'h1, 8'hc5 ^ 8'(k), ca[k], 1'h1);
			access(ca[k], 1'h0, 8'h00, ~ca[k], 1'h0);
		end
		repeat (400) begin
			r = $urandom;
			q = $urandom;
			case (r[30:28])
				3'h0: a = {2'h3, r[13:0]};
				3'h1: a = {2'h2, r[13:0]};
				3'h2: a = {8'h7f, r[7:0]};
				3'h3: a = {8'h7f, r[1] ? {7'h14, r[0]} : 8'h71 + 8'(r[0])};
				3'h4: a = {4'h5, r[11:0]};
				3'h5: a = {7'h20, r[8:0]};
				3'h6: a = {4'h6, r[11:0] & {12{r[12]}}};
				default: a = r[15:0];
			endcase
			access(a, r[16], q[31:24], q[15:0], q[16]);
			if (r[17] && r[18]) begin
				@(negedge clk);
				rd = 1'h0;
				wr = 1'h0;
				@(posedge clk);
				#1 chk("idle_strobes", {62'h0, mo.flash_rd_n, mo.blk_rd}, 64'h2);
			end
		end
		do_reset();
		access(16'h7f29, 1'h0, 8'h00, 16'h0, 1'h0);
		access(16'h7f28, 1'h0, 8'h00, 16'h0, 1'h0);
		access(16'hc001, 1'h0, 8'h00, 16'h0, 1'h0);
		// Page select write followed at once by an upper quarter read
		access(16'h7f29, 1'h1, 8'h05, 16'h8c85, 1'h1);
		access(16'hc000, 1'h0, 8'h00, 16'h0, 1'h0);
		end_sim();
	end
endmodule // tb_mcu_and_dma_address_decoder

`default_nettype wire
